// file: hw/rld_pkg.sv
// Purpose: Constants for the register-load instruction decoder
// Assumes: 10-bit instruction words, 4-bit data path
// Notes:   Opcodes and reset values of the peripheral control registers
package rld_pkg;
  localparam int          OPCODE_W         = 10;
  localparam int          NIBBLE_W         = 4;
  localparam int          SERIAL_W         = 8;
  localparam logic [9:0]  OP_LOAD_SERIAL   = 10'h238;
  localparam logic [9:0]  OP_LOAD_IRQ_1    = 10'h03F;
  localparam logic [9:0]  OP_LOAD_IRQ_2    = 10'h03E;
  localparam logic [9:0]  OP_LOAD_TIMER_1  = 10'h20E;
  localparam logic [3:0]  NIBBLE_RESET     = 4'h0;
  localparam logic [7:0]  SERIAL_RESET     = 8'h00;
  localparam logic [1:0]  SYNC_RESET       = 2'h0;

  typedef enum logic [2:0]
  {
    RLD_NONE         = 3'b000,
    RLD_LOAD_SERIAL  = 3'b001,
    RLD_LOAD_IRQ_1   = 3'b010,
    RLD_LOAD_IRQ_2   = 3'b011,
    RLD_LOAD_TIMER_1 = 3'b100
  } rld_op_e;

  // Classify one instruction word
  function automatic rld_op_e rld_classify(input logic [9:0] word);
    rld_op_e op;
    op = RLD_NONE;
    if (word == OP_LOAD_SERIAL)
      op = RLD_LOAD_SERIAL;
    else if (word == OP_LOAD_IRQ_1)
      op = RLD_LOAD_IRQ_1;
    else if (word == OP_LOAD_IRQ_2)
      op = RLD_LOAD_IRQ_2;
    else if (word == OP_LOAD_TIMER_1)
      op = RLD_LOAD_TIMER_1;
    return op;
  endfunction : rld_classify
endpackage : rld_pkg

// file: hw/rld_nibble_reg.sv
// Purpose: Loadable register with reset value
// Assumes: Synchronous load, async active-low reset
// Notes:   Used for each nibble-wide peripheral control register; the serial register is built separately
module rld_nibble_reg #(
  parameter int          W     = 4,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] data_i,
  output logic      [W-1:0] value_o
);
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      value_o <= INIT;
    else if (load_i)
      value_o <= data_i;
  end
endmodule : rld_nibble_reg

// file: hw/rld_decoder.sv
// Purpose: Decode four transfer instructions into peripheral control loads
// Assumes: One instruction word per valid cycle from the fetch path
// Notes:   Carry and skip outputs are never raised by these instructions
module rld_decoder (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       instr_valid_i,
  input  wire logic [9:0] instr_i,
  input  wire logic [3:0] accum_i,
  input  wire logic [3:0] companion_i,
  output logic      [7:0] serial_data_o,
  output logic            serial_loaded_o,
  output logic      [3:0] irq_control_first_o,
  output logic      [3:0] irq_control_second_o,
  output logic      [3:0] timer_control_first_o,
  output logic            done_o,
  output logic            carry_write_o,
  output logic            skip_next_o
);
  logic [1:0]      rst_sync_q;
  logic            rst_n;
  rld_pkg::rld_op_e op;
  logic            ld_serial;
  logic            ld_irq1;
  logic            ld_irq2;
  logic            ld_tmr1;

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_q <= rld_pkg::SYNC_RESET;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  always_comb
  begin
    op = instr_valid_i ? rld_pkg::rld_classify(instr_i) : rld_pkg::RLD_NONE;
  end
  assign ld_serial = (op == rld_pkg::RLD_LOAD_SERIAL);
  assign ld_irq1   = (op == rld_pkg::RLD_LOAD_IRQ_1);
  assign ld_irq2   = (op == rld_pkg::RLD_LOAD_IRQ_2);
  assign ld_tmr1   = (op == rld_pkg::RLD_LOAD_TIMER_1);

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      serial_data_o <= rld_pkg::SERIAL_RESET;
    else if (ld_serial)
      serial_data_o <= {companion_i, accum_i};
  end

  rld_nibble_reg #(.W(4), .INIT(rld_pkg::NIBBLE_RESET)) u_irq1 (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .load_i  (ld_irq1),
    .data_i  (accum_i),
    .value_o (irq_control_first_o)
  );

  rld_nibble_reg #(.W(4), .INIT(rld_pkg::NIBBLE_RESET)) u_irq2 (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .load_i  (ld_irq2),
    .data_i  (accum_i),
    .value_o (irq_control_second_o)
  );

  rld_nibble_reg #(.W(4), .INIT(rld_pkg::NIBBLE_RESET)) u_tmr1 (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .load_i  (ld_tmr1),
    .data_i  (accum_i),
    .value_o (timer_control_first_o)
  );

  // Serial pulse marks each load of the shift register
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      serial_loaded_o <= 1'b0;
    else
      serial_loaded_o <= ld_serial;
  end

  // Completion strobe one cycle after each decoded transfer
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      done_o <= 1'b0;
    else
      done_o <= (op != rld_pkg::RLD_NONE);
  end

  // Carry flag is never written by these transfers
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      carry_write_o <= 1'b0;
    else
      carry_write_o <= 1'b0;
  end

  // Next word is never skipped
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      skip_next_o <= 1'b0;
    else
      skip_next_o <= 1'b0;
  end

  // Request and answer steps
  sequence serial_request_s;
    ld_serial;
  endsequence

  sequence serial_answer_s;
    ##1 (serial_loaded_o && done_o);
  endsequence

  sequence any_request_s;
    (op != rld_pkg::RLD_NONE);
  endsequence

  sequence done_answer_s;
    ##1 done_o;
  endsequence

  sequence no_request_s;
    (op == rld_pkg::RLD_NONE);
  endsequence

  sequence quiet_answer_s;
    ##1 (!done_o && !serial_loaded_o);
  endsequence

  // Serial shift register
  serial_load_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    ld_serial |=> serial_data_o == {$past(companion_i), $past(accum_i)} && serial_loaded_o)
    else $error("Serial register not loaded from pair");
  serial_high_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    ld_serial |=> serial_data_o[7:4] == $past(companion_i))
    else $error("Serial high nibble wrong");
  serial_only_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    ld_serial |=> $stable(irq_control_first_o) && $stable(irq_control_second_o) && $stable(timer_control_first_o))
    else $error("Serial load touched another register");
  serial_low_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    ld_serial |=> serial_data_o[3:0] == $past(accum_i))
    else $error("Serial low nibble wrong");
  serial_hold_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    !ld_serial |=> $stable(serial_data_o))
    else $error("Serial register changed without load");
  serial_pulse_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    serial_request_s |-> serial_answer_s)
    else $error("Serial load pulse missing");
  pulse_quiet_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    !ld_serial |=> !serial_loaded_o)
    else $error("Serial load pulse without load");

  // First interrupt control
  irq_first_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    ld_irq1 |=> irq_control_first_o == $past(accum_i))
    else $error("First interrupt control not loaded");
  irq_first_hold_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    !ld_irq1 |=> $stable(irq_control_first_o))
    else $error("First interrupt control changed without load");
  irq_first_only_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    ld_irq1 |=> $stable(irq_control_second_o) && $stable(timer_control_first_o))
    else $error("First interrupt load touched another register");

  // Second interrupt control
  irq_second_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    ld_irq2 |=> irq_control_second_o == $past(accum_i) && $stable(irq_control_first_o))
    else $error("Second interrupt control not loaded");
  irq_second_hold_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    !ld_irq2 |=> $stable(irq_control_second_o))
    else $error("Second interrupt control changed without load");
  irq_second_only_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    ld_irq2 |=> $stable(timer_control_first_o) && $stable(serial_data_o))
    else $error("Second interrupt load touched another register");

  // Timer control
  timer_first_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    ld_tmr1 |=> timer_control_first_o == $past(accum_i) && $stable(irq_control_second_o))
    else $error("Timer control not loaded");
  timer_hold_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    !ld_tmr1 |=> $stable(timer_control_first_o))
    else $error("Timer control changed without load");
  timer_only_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    ld_tmr1 |=> $stable(irq_control_first_o) && $stable(serial_data_o))
    else $error("Timer load touched another register");

  // Completion and side effects
  one_cycle_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    any_request_s |-> done_answer_s)
    else $error("Transfer did not finish in one cycle");
  idle_quiet_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    no_request_s |-> quiet_answer_s)
    else $error("Strobe raised without transfer");
  invalid_ignored_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    !instr_valid_i |=> !done_o && !serial_loaded_o)
    else $error("Word without valid was executed");
  done_serial_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    serial_loaded_o |-> done_o)
    else $error("Serial pulse without completion");
  no_side_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    done_o |-> !carry_write_o && !skip_next_o)
    else $error("Transfer touched carry or skip");
  carry_quiet_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    !carry_write_o)
    else $error("Carry write raised");
  skip_quiet_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    !skip_next_o)
    else $error("Skip raised");

endmodule : rld_decoder

// file: testbench/tb_rld_decoder.sv
// Purpose: Self-checking bench for the register-load instruction decoder
// Assumes: Inputs driven at falling edge, results read just after rising edge
// Notes:   Loads, back-to-back issue, ignored words, reset values
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin n_errors++; \
  $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module tb_rld_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock_i       = 1'b0;
  logic       reset_n_i     = 1'b0;
  logic       instr_valid_i = 1'b0;
  logic [9:0] instr_i       = 10'h000;
  logic [3:0] accum_i       = 4'h0;
  logic [3:0] companion_i   = 4'h0;
  logic [7:0] serial_data_o;
  logic       serial_loaded_o, done_o, carry_write_o, skip_next_o;
  logic [3:0] irq_control_first_o, irq_control_second_o, timer_control_first_o;
  int         n_errors   = 0;
  int         n_compared = 0;

  always #12.5 clock_i = ~clock_i;

  rld_decoder rld_decoder_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .accum_i(accum_i), .companion_i(companion_i), .serial_data_o(serial_data_o),
    .serial_loaded_o(serial_loaded_o), .irq_control_first_o(irq_control_first_o),
    .irq_control_second_o(irq_control_second_o), .timer_control_first_o(timer_control_first_o),
    .done_o(done_o), .carry_write_o(carry_write_o), .skip_next_o(skip_next_o));

  // Present one word at the falling edge, return just after the taking edge
  task automatic step(input logic [9:0] op, input logic [3:0] a, input logic [3:0] b, input logic v);
    @(negedge clock_i);
    instr_valid_i = v;
    instr_i       = op;
    accum_i       = a;
    companion_i   = b;
    @(posedge clock_i);
    #1;
  endtask : step

  task automatic check_reset_values();
    `CHK("serial", 8'h00, serial_data_o)
    `CHK("irq first", 4'h0, irq_control_first_o)
    `CHK("irq second", 4'h0, irq_control_second_o)
    `CHK("timer first", 4'h0, timer_control_first_o)
    `CHK("done", 1'b0, done_o)
    `CHK("serial pulse", 1'b0, serial_loaded_o)
    `CHK("carry", 1'b0, carry_write_o)
    `CHK("skip", 1'b0, skip_next_o)
  endtask : check_reset_values

  task automatic check_loads_back_to_back();
    step(10'h238, 4'h5, 4'hA, 1'b1);
    `CHK("serial high", 4'hA, serial_data_o[7:4])
    `CHK("serial low", 4'h5, serial_data_o[3:0])
    `CHK("serial pulse", 1'b1, serial_loaded_o)
    `CHK("done", 1'b1, done_o)
    step(10'h03F, 4'h3, 4'hF, 1'b1);
    `CHK("irq first", 4'h3, irq_control_first_o)
    `CHK("serial held", 8'hA5, serial_data_o)
    `CHK("serial pulse end", 1'b0, serial_loaded_o)
    step(10'h03E, 4'hC, 4'h1, 1'b1);
    `CHK("irq second", 4'hC, irq_control_second_o)
    `CHK("irq first held", 4'h3, irq_control_first_o)
    step(10'h20E, 4'h9, 4'h2, 1'b1);
    `CHK("timer first", 4'h9, timer_control_first_o)
    step(10'h20E, 4'h6, 4'h2, 1'b1);
    `CHK("timer reload", 4'h6, timer_control_first_o)
    `CHK("done", 1'b1, done_o)
    `CHK("carry", 1'b0, carry_write_o)
    `CHK("skip", 1'b0, skip_next_o)
  endtask : check_loads_back_to_back

  task automatic check_ignored_words();
    step(10'h03F, 4'h7, 4'h0, 1'b0);
    `CHK("irq first idle", 4'h3, irq_control_first_o)
    `CHK("done idle", 1'b0, done_o)
    step(10'h238, 4'h1, 4'h1, 1'b0);
    `CHK("serial idle", 8'hA5, serial_data_o)
    `CHK("pulse idle", 1'b0, serial_loaded_o)
    step(10'h239, 4'hE, 4'hE, 1'b1);
    `CHK("done other op", 1'b0, done_o)
    `CHK("serial other op", 8'hA5, serial_data_o)
    `CHK("pulse other op", 1'b0, serial_loaded_o)
    `CHK("irq second other", 4'hC, irq_control_second_o)
    `CHK("timer other", 4'h6, timer_control_first_o)
    step(10'h000, 4'h0, 4'h0, 1'b0);
  endtask : check_ignored_words

  task automatic check_mid_reset();
    @(negedge clock_i);
    reset_n_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    `CHK("serial after reset", 8'h00, serial_data_o)
    `CHK("irq first after reset", 4'h0, irq_control_first_o)
    `CHK("timer after reset", 4'h0, timer_control_first_o)
    @(negedge clock_i);
    reset_n_i = 1'b1;
    repeat (3) @(posedge clock_i);
    step(10'h03E, 4'h8, 4'h0, 1'b1);
    `CHK("irq second after reset", 4'h8, irq_control_second_o)
    `CHK("done after reset", 1'b1, done_o)
  endtask : check_mid_reset

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (16) @(posedge clock_i);
    @(negedge clock_i);
    check_reset_values();
    reset_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    check_loads_back_to_back();
    check_ignored_words();
    check_mid_reset();
    complete_run();
  end
endmodule : tb_rld_decoder
